// >>> rtc_core.sv
// Clock registers behind an asynchronous SRAM-style bus, BCD time counters.
// Assumes bus pins and power-down are asynchronous; only the eight clock
// registers at the top of the map are answered here.
`include "rtc_map.svh"
`timescale 1ns/10ps
`default_nettype none
module rtc_core import rtc_pkg::*; #(
   parameter int CLK_HZ = `RTC_CLK_HZ,
   parameter int OSC_HZ = `RTC_OSC_HZ
) (
   input wire logic CLOCK,        // 25 MHz clock
   input wire logic RST,          // Async reset, high
   input wire logic E_N,          // Chip enable, low
   input wire logic G_N,          // Output enable, low
   input wire logic W_N,          // Write enable, low
   input wire logic [14:0] ADDR,  // Byte address
   input wire logic [7:0] DQ_I,   // Data from host
   input wire logic POWER_DOWN,   // Supply failing, high
   output logic [7:0] DQ_O,       // Data to host
   output logic DQ_OE             // Data drive enable
);
   localparam logic [14:0] BASE = `RTC_OFF_CTL;
   localparam logic [2:0] I_CTL = 3'h0;
   localparam logic [2:0] I_SEC = 3'(`RTC_OFF_SEC - `RTC_OFF_CTL);
   localparam logic [2:0] I_MIN = 3'(`RTC_OFF_MIN - `RTC_OFF_CTL);
   localparam logic [2:0] I_HR = 3'(`RTC_OFF_HR - `RTC_OFF_CTL);
   localparam logic [2:0] I_DAY = 3'(`RTC_OFF_DAY - `RTC_OFF_CTL);
   localparam logic [2:0] I_DATE = 3'(`RTC_OFF_DATE - `RTC_OFF_CTL);
   localparam logic [2:0] I_MON = 3'(`RTC_OFF_MON - `RTC_OFF_CTL);
   localparam logic [2:0] I_YR = 3'(`RTC_OFF_YR - `RTC_OFF_CTL);
   localparam int BW = $bits(rtc_bus_t);
   // Idle pin levels, so the edge register sees no write ending after reset
   localparam logic [BW-1:0] BUS_IDLE = {1'b0, 1'b1, 1'b1, 1'b1, 15'h0000, 8'h00};

   // Clock block hit test, used for reads and writes
   function automatic logic is_clk(input logic [14:0] a);
      is_clk = (a[14:3] == BASE[14:3]);
   endfunction

   // Register select, one-hot on the low address bits
   function automatic logic [7:0] sel(input logic [14:0] a);
      sel = is_clk(a) ? (8'h01 << a[2:0]) : 8'h00;
   endfunction

   // Two-digit BCD increment
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   // Leap year in BCD: tens even with units 0,4,8 or tens odd with 2,6
   function automatic logic leap(input logic [7:0] y);
      if (y[4]) begin
         leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
      end else begin
         leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
      end
   endfunction

   // Last date of the month in BCD
   function automatic logic [5:0] last_date(input logic [4:0] m,
                                            input logic [7:0] y);
      case (m)
         5'h02: last_date = leap(y) ? 6'h29 : 6'h28;
         5'h04, 5'h06, 5'h09, 5'h11: last_date = 6'h30;
         default: last_date = 6'h31;
      endcase
   endfunction

   logic [BW-1:0] s1_r;
   logic [BW-1:0] s2_r;
   rtc_bus_t q_r;
   logic [7:0] ctl_r;
   logic halt_r;
   logic ft_r;
   logic ceb_r;
   rtc_time_t vis_r;
   rtc_time_t vis_nxt;
   rtc_time_t cnt_r;
   rtc_time_t cnt_nxt;
   localparam rtc_time_t RST_TIME = '{sec: 7'h00, min: 7'h00, hr: 6'h00, day: 3'h1,
                                      date: 6'h01, mon: 5'h01, yr: 8'h00, cent: 1'b0};
   logic [5:0] cal_min_r;
   logic [5:0] cal_min_nxt;
   logic [7:0] rd_data;

   rtc_bus_t b;
   logic wr_act;
   logic wr_act_q;
   logic commit;
   logic [7:0] wsel;
   logic [7:0] wd;
   logic rd_act;
   logic rd_hit;
   logic wfrz;
   logic frz_any;
   logic release_w;
   logic sec_tick;
   logic test_wave;
   logic cal_adj;
   logic min_wrap;
   logic test_on;

   // Bus pins after the two-stage synchroniser, then one delay for edges
   assign b = rtc_bus_t'(s2_r);
   assign wr_act = !b.e_n && !b.w_n;
   assign wr_act_q = !q_r.e_n && !q_r.w_n;
   // A write lands when the first of E or W rises; data held from before
   assign commit = wr_act_q && !wr_act;
   assign wsel = commit ? sel(q_r.addr) : 8'h00;
   assign wd = q_r.data;
   assign rd_act = !b.e_n && !b.g_n && b.w_n;
   assign rd_hit = rd_act && is_clk(b.addr);

   assign wfrz = ctl_r[`RTC_CTL_WFRZ];
   assign frz_any = wfrz || ctl_r[`RTC_CTL_RFRZ];
   assign release_w = wsel[I_CTL] && wfrz && !wd[`RTC_CTL_WFRZ];

   // One corrected second per eligible minute, first 2N of the first 62
   assign cal_adj = (ctl_r[4:0] != 5'h00) &&
                    (cal_min_r < {ctl_r[4:0], 1'b0}) &&
                    (cal_min_r < `RTC_CAL_MINS) &&
                    (cnt_r.sec == 7'h00);
   assign min_wrap = sec_tick && (cnt_r.sec == 7'h59);
   assign cal_min_nxt = min_wrap ? cal_min_r + 6'h01 : cal_min_r;
   assign test_on = ft_r && !halt_r;

   rtc_tbase #(
      .CLK_HZ(CLK_HZ),
      .OSC_HZ(OSC_HZ)
   ) u_tbase (
      .clk(CLOCK),
      .rst(RST),
      .run(!halt_r),
      .adj(cal_adj),
      .adj_pos(ctl_r[`RTC_CTL_SIGN]),
      .sec_tick(sec_tick),
      .test_wave(test_wave)
   );

   // Counters: load on release, else count in BCD with full carry chain
   always_comb begin
      cnt_nxt = cnt_r;
      if (release_w) begin
         cnt_nxt = vis_r;
      end else if (sec_tick) begin
         cnt_nxt.sec = 7'(bcd_inc({1'b0, cnt_r.sec}));
         if (cnt_r.sec == 7'h59) begin
            cnt_nxt.sec = 7'h00;
            cnt_nxt.min = 7'(bcd_inc({1'b0, cnt_r.min}));
            if (cnt_r.min == 7'h59) begin
               cnt_nxt.min = 7'h00;
               cnt_nxt.hr = 6'(bcd_inc({2'b00, cnt_r.hr}));
               if (cnt_r.hr == 6'h23) begin
                  cnt_nxt.hr = 6'h00;
                  cnt_nxt.day = (cnt_r.day == 3'h7) ? 3'h1 : cnt_r.day + 3'h1;
                  cnt_nxt.date = 6'(bcd_inc({2'b00, cnt_r.date}));
                  if (cnt_r.date >= last_date(cnt_r.mon, cnt_r.yr)) begin
                     cnt_nxt.date = 6'h01;
                     cnt_nxt.mon = 5'(bcd_inc({3'b000, cnt_r.mon}));
                     if (cnt_r.mon == 5'h12) begin
                        cnt_nxt.mon = 5'h01;
                        cnt_nxt.yr = bcd_inc(cnt_r.yr);
                        if (cnt_r.yr == 8'h99) begin
                           cnt_nxt.yr = 8'h00;
                           cnt_nxt.cent = cnt_r.cent ^ ceb_r;
                        end
                     end
                  end
               end
            end
         end
      end
   end

   // Visible registers: follow the counters unless frozen, take writes
   always_comb begin
      vis_nxt = vis_r;
      if (!frz_any) begin
         vis_nxt = cnt_r;
      end
      if (wsel[I_SEC]) begin
         vis_nxt.sec = wd[6:0];
      end
      if (wsel[I_MIN]) begin
         vis_nxt.min = wd[6:0];
      end
      if (wsel[I_HR]) begin
         vis_nxt.hr = wd[5:0];
      end
      if (wsel[I_DAY]) begin
         vis_nxt.day = wd[2:0];
      end
      if (wsel[I_DAY] && wfrz) begin
         vis_nxt.cent = wd[`RTC_DAY_CENT];
      end
      if (wsel[I_DATE]) begin
         vis_nxt.date = wd[5:0];
      end
      if (wsel[I_MON]) begin
         vis_nxt.mon = wd[4:0];
      end
      if (wsel[I_YR]) begin
         vis_nxt.yr = wd;
      end
   end

   // Read data, fixed-zero bits read as zero
   always_comb begin
      case (b.addr[2:0])
         I_CTL: rd_data = ctl_r;
         I_SEC: begin
            rd_data = {halt_r, vis_r.sec};
            if (test_on) begin
               rd_data[0] = test_wave;
            end
         end
         I_MIN: rd_data = {1'b0, vis_r.min};
         I_HR: rd_data = {2'b00, vis_r.hr};
         I_DAY: rd_data = {1'b0, ft_r, ceb_r, vis_r.cent, 1'b0, vis_r.day};
         I_DATE: rd_data = {2'b00, vis_r.date};
         I_MON: rd_data = {3'b000, vis_r.mon};
         I_YR: rd_data = vis_r.yr;
         default: rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         s1_r <= BUS_IDLE;
         s2_r <= BUS_IDLE;
         q_r <= rtc_bus_t'(BUS_IDLE);
      end else begin
         s1_r <= {POWER_DOWN, E_N, G_N, W_N, ADDR, DQ_I};
         s2_r <= s1_r;
         q_r <= b;
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         ctl_r <= `RTC_RST_CTL;
         halt_r <= `RTC_RST_HALT;
         ft_r <= 1'b0;
         ceb_r <= 1'b0;
      end else begin
         if (wsel[I_CTL]) ctl_r <= wd;
         if (wsel[I_SEC]) halt_r <= wd[`RTC_SEC_HALT];
         if (b.pdn) begin
            ft_r <= 1'b0;
         end else if (wsel[I_DAY]) begin
            ft_r <= wd[`RTC_DAY_FT];
         end
         if (wsel[I_DAY]) ceb_r <= wd[`RTC_DAY_CEB];
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         vis_r <= RST_TIME;
         cnt_r <= RST_TIME;
         cal_min_r <= 6'h00;
      end else begin
         vis_r <= vis_nxt;
         cnt_r <= cnt_nxt;
         cal_min_r <= cal_min_nxt;
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         DQ_O <= 8'h00;
         DQ_OE <= 1'b0;
      end else begin
         DQ_O <= rd_hit ? rd_data : 8'h00;
         DQ_OE <= rd_hit;
      end
   end
endmodule // rtc_core
`default_nettype wire

// >>> rtc_core_assertions.sv
// Pin-level checks on the clock core bus and power-down input.
// Bound into rtc_core; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module rtc_core_assertions #(
   parameter int CLK_HZ = 25000000,
   parameter int OSC_HZ = 32768
) (
   input wire logic CLOCK, // Clock
   input wire logic RST, // Reset
   input wire logic E_N, // Enable
   input wire logic G_N, // Output enable
   input wire logic W_N, // Write enable
   input wire logic [14:0] ADDR, // Address
   input wire logic [7:0] DQ_I, // Write data
   input wire logic POWER_DOWN, // Power fail
   input wire logic [7:0] DQ_O, // Read data
   input wire logic DQ_OE // Drive enable
);
   logic [14:0] a1_r, a2_r, a3_r;
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         {a3_r, a2_r, a1_r} <= '0;
      end else begin
         {a3_r, a2_r, a1_r} <= {a2_r, a1_r, ADDR};
      end
   end
   wire logic rd = !E_N && !G_N && W_N && ADDR[14:3] == 12'hFFF;
   wire logic rd_at = DQ_OE && a3_r == a2_r;
   wire logic sec_rd = rd_at && a3_r == 15'h7FF9;
   wire logic [7:0] zm = a3_r == 15'h7FFA ? 8'h80 : a3_r == 15'h7FFC ? 8'h88 :
      a3_r == 15'h7FFE ? 8'hE0 : a3_r[2:0] == 3'h3 || a3_r[2:0] == 3'h5 ? 8'hC0 : 8'h00;
   default clocking dc @(posedge CLOCK);
   endclocking
   default disable iff (RST);
   sequence rd_held;
      rd[*4];
   endsequence
   sequence pd_held;
      POWER_DOWN[*6];
   endsequence
   a_oe_from_read: assert property (DQ_OE |-> $past(rd, 3))
      else $error("data driven without a read");
   a_read_drives_oe: assert property (rd_held |=> ##2 DQ_OE)
      else $error("read not answered");
   a_idle_data_zero: assert property (!DQ_OE |-> DQ_O == 8'h00)
      else $error("data not zero while idle");
   a_write_quiets: assert property ((!W_N)[*4] |-> !DQ_OE)
      else $error("drive during write");
   a_fixed_zeros: assert property (rd_at |-> (DQ_O & zm) == 8'h00)
      else $error("fixed zero bit set");
   a_bcd_seconds: assert property (sec_rd |-> DQ_O[3:0] <= 4'h9 && DQ_O[6:4] <= 3'h5)
      else $error("seconds not BCD");
   a_hours_range: assert property (rd_at && a3_r == 15'h7FFB |-> DQ_O[5:0] <= 6'h23)
      else $error("hours out of range");
   a_pd_clears_ft: assert property (pd_held ##0 (rd_at && a3_r == 15'h7FFC) |-> !DQ_O[6])
      else $error("test enable kept in power-down");
   a_halt_holds: assert property (sec_rd && DQ_O[7] ##1 sec_rd && DQ_O[7] |-> $stable(DQ_O))
      else $error("seconds moved while halted");
endmodule // rtc_core_assertions
bind rtc_core rtc_core_assertions #(.CLK_HZ(CLK_HZ), .OSC_HZ(OSC_HZ)) u_chk (
   .CLOCK(CLOCK), .RST(RST), .E_N(E_N), .G_N(G_N), .W_N(W_N), .ADDR(ADDR),
   .DQ_I(DQ_I), .POWER_DOWN(POWER_DOWN), .DQ_O(DQ_O), .DQ_OE(DQ_OE));
`default_nettype wire

// >>> rtc_core_tb.sv
// Bench for rtc_core: reset values, set-time, halt, test wave, power-down.
// Assumes one oscillator tick per clock, so a second is 32768 clocks.
`timescale 1ns/10ps
`default_nettype none
module rtc_core_tb import rtc_pkg::*; ;
   localparam logic [7:0] RST_V [8] = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
   localparam logic [7:0] SET_V [7] = '{8'h59, 8'h59, 8'h23, 8'h37, 8'h31, 8'h12, 8'h99};
   localparam logic [7:0] ROLL_V [7] = '{8'h00, 8'h00, 8'h00, 8'h21, 8'h01, 8'h01, 8'h00};
   logic clock;
   logic rst;
   rtc_bus_t bus;
   logic [7:0] dq_o;
   logic dq_oe;
   logic [15:0] res;
   logic res_vld;
   logic track;
   logic [15:0] exp_q [$];
   int n_mismatch;
   int num_checks;
   int seed;
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   rtc_core #(.CLK_HZ(25000000), .OSC_HZ(25000000)) DUT (.CLOCK(clock), .RST(rst),
      .E_N(bus.e_n), .G_N(bus.g_n), .W_N(bus.w_n), .ADDR(bus.addr), .DQ_I(bus.data),
      .POWER_DOWN(bus.pdn), .DQ_O(dq_o), .DQ_OE(dq_oe));
   rtc_host host (.clk(clock), .bus(bus), .dq_o(dq_o), .dq_oe(dq_oe), .res(res),
      .res_vld(res_vld));
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [14:0] a, input logic [15:0] e, input int per);
      exp_q.push_back(e);
      track = 1'b1;
      host.rd(a, per);
      track = 1'b0;
   endtask
   task automatic wait_sec;
      int k;
      k = 0;
      do begin
         host.rd(15'h7FF9, 0);
         k++;
      end while (res[7:0] !== 8'h00 && k < 3600);
      if (res[7:0] !== 8'h00) begin
         n_mismatch++;
         $display("[ERR] %0t second did not roll over", $time);
         print_verdict();
      end
   endtask
   always @(posedge clock) begin
      if (res_vld === 1'b1 && track === 1'b1 && exp_q.size() > 0) begin
         num_checks++;
         if (res !== exp_q[0]) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, res, exp_q[0]);
         end
         void'(exp_q.pop_front());
      end
   end
   initial begin
      logic [31:0] r;
      seed = 1;
      n_mismatch = 0;
      num_checks = 0;
      track = 1'b0;
      rst = 1'b1;
      repeat (6) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      r = $random(seed);
      host.wr({1'b0, r[13:0]}, r[21:14]);
      chk({1'b0, r[29:16]}, 16'h0000, 0);
      for (int i = 0; i < 8; i++) chk(15'h7FF8 + 15'(i), {8'h01, RST_V[i]}, 0);
      host.wr(15'h7FFC, 8'h31);
      chk(15'h7FFC, 16'h0121, 0);
      host.wr(15'h7FF8, 8'h80);
      for (int i = 0; i < 7; i++) host.wr(15'h7FF9 + 15'(i), SET_V[i]);
      for (int i = 0; i < 7; i++) chk(15'h7FF9 + 15'(i), {8'h01, SET_V[i]}, 0);
      host.wr(15'h7FF8, 8'h00);
      wait_sec();
      for (int i = 0; i < 7; i++) chk(15'h7FF9 + 15'(i), {8'h01, ROLL_V[i]}, 0);
      host.wr(15'h7FF8, 8'h80);
      host.wr(15'h7FF9, 8'h80);
      host.wr(15'h7FF8, 8'h00);
      repeat (33000) @(negedge clock);
      chk(15'h7FF9, 16'h0180, 0);
      host.wr(15'h7FFC, 8'h61);
      chk(15'h7FF9, 16'hFFFF, 200);
      host.wr(15'h7FF8, 8'h80);
      host.wr(15'h7FF9, 8'h00);
      host.wr(15'h7FF8, 8'h00);
      chk(15'h7FF9, 16'h0040, 200);
      r = $random(seed);
      host.wr(15'h7FF8, {2'b00, r[5:0]});
      chk(15'h7FF9, 16'h0040, 200);
      host.power(1'b1);
      chk(15'h7FFC, 16'h0121, 0);
      host.power(1'b0);
      chk(15'h7FFC, 16'h0121, 0);
      print_verdict();
   end
endmodule // rtc_core_tb
`default_nettype wire

// >>> rtc_host.sv
// Host processor model on the asynchronous SRAM-style bus.
// Driven by bench tasks; pins change at the falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module rtc_host import rtc_pkg::*; (
   input wire logic clk, // Bench clock
   output var rtc_bus_t bus, // Pins to the core
   input wire logic [7:0] dq_o, // Read data
   input wire logic dq_oe, // Core drives data
   output logic [15:0] res, // Last result
   output logic res_vld // Result strobe
);
   initial begin
      bus = '{pdn: 1'b0, e_n: 1'b1, g_n: 1'b1, w_n: 1'b1, addr: 15'h0000, data: 8'h00};
      res = 16'h0000;
      res_vld = 1'b0;
   end
   task automatic gap(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic power(input logic v);
      @(negedge clk);
      bus.pdn = v;
      gap(4);
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      @(negedge clk);
      bus.addr = a;
      bus.data = d;
      {bus.e_n, bus.w_n} = 2'b00;
      gap(4);
      {bus.e_n, bus.w_n} = 2'b11;
      gap(4);
      // Released data lines show a changed value
      bus.data = ~d;
   endtask
   // With per above zero, measures the period of read bit 0 in clocks
   task automatic rd(input logic [14:0] a, input int per);
      int t0;
      logic b0;
      @(negedge clk);
      bus.addr = a;
      {bus.e_n, bus.g_n} = 2'b00;
      repeat (4) @(negedge clk);
      res = {7'h00, dq_oe, dq_o};
      t0 = -1;
      b0 = 1'b1;
      if (per > 0) res = 16'hFFFF;
      for (int n = 0; n < per; n++) begin
         @(negedge clk);
         if (dq_o[0] && !b0 && t0 >= 0 && res == 16'hFFFF) res = 16'(n - t0);
         if (dq_o[0] && !b0) t0 = n;
         b0 = dq_o[0];
      end
      @(negedge clk);
      res_vld = 1'b1;
      {bus.e_n, bus.g_n} = 2'b11;
      @(negedge clk);
      res_vld = 1'b0;
      gap(3);
   endtask
endmodule // rtc_host
`default_nettype wire

// >>> rtc_map.svh
// Offsets, field positions, reset values and timing counts of the clock core.
// Assumes it is included by bare name after the package.
// What this block does
// - Write-freeze bit D7 of control stops visible register updates.
// - Clearing write-freeze copies all time registers into the counters.
// - Visible registers resume updating within one second after release.
// - Seconds MSB halts the oscillator when 1, restarts it when 0.
// - Oscillator runs within one second of the halt bit clearing.
// - Halt bit comes out of reset set, oscillator stopped.
// - Calibration magnitude is control bits D4-D0, unsigned 0 to 31.
// - Control D5 picks direction: 1 speeds up, 0 slows down.
// - Correction splits or blanks pulses at the divide-by-256 stage.
// - 64-minute cycle; one second per eligible minute is shortened 128 or lengthened 256.
// - Magnitude N modifies only the first 2N minutes of the cycle.
// - Test enable set and oscillator running toggles lowest data line at 512 Hz.
// - Test toggle rate does not depend on calibration.
// - Power-down clears the test enable bit.
// - Century flag toggles at century turn only when its enable is set.
// - Century-toggle enable accepts writes regardless of write-freeze.
// - Timebase is a 32,768 Hz oscillator divided down to one second.
// - Read-freeze bit D6 holds visible registers without disturbing counters.
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
`define RTC_OFF_CTL 15'h7FF8
`define RTC_OFF_SEC 15'h7FF9
`define RTC_OFF_MIN 15'h7FFA
`define RTC_OFF_HR 15'h7FFB
`define RTC_OFF_DAY 15'h7FFC
`define RTC_OFF_DATE 15'h7FFD
`define RTC_OFF_MON 15'h7FFE
`define RTC_OFF_YR 15'h7FFF
`define RTC_CTL_WFRZ 7
`define RTC_CTL_RFRZ 6
`define RTC_CTL_SIGN 5
`define RTC_SEC_HALT 7
`define RTC_DAY_FT 6
`define RTC_DAY_CEB 5
`define RTC_DAY_CENT 4
`define RTC_RST_CTL 8'h00
`define RTC_RST_HALT 1'b1
`define RTC_CLK_HZ 25000000
`define RTC_OSC_HZ 32768
`define RTC_SEC_NOM 16'h8000
`define RTC_SEC_SHORT 16'h7F80
`define RTC_SEC_LONG 16'h8100
`define RTC_CAL_MINS 6'h3E
`define RTC_TEST_BIT 5
`endif

// >>> rtc_pkg.sv
// Types shared by the clock core, the host model and the bench.
// Assumes nothing of its surroundings.
package rtc_pkg;
   typedef struct packed {
      logic [6:0] sec;
      logic [6:0] min;
      logic [5:0] hr;
      logic [2:0] day;
      logic [5:0] date;
      logic [4:0] mon;
      logic [7:0] yr;
      logic cent;
   } rtc_time_t;
   typedef struct packed {
      logic pdn;
      logic e_n;
      logic g_n;
      logic w_n;
      logic [14:0] addr;
      logic [7:0] data;
   } rtc_bus_t;
endpackage

// >>> rtc_tbase.sv
// Oscillator model, calibrated one-second divider and 512 Hz test wave.
// Assumes run and adj come from flops on the same clock.
`include "rtc_map.svh"
`timescale 1ns/10ps
`default_nettype none
module rtc_tbase #(
   parameter int CLK_HZ = `RTC_CLK_HZ,
   parameter int OSC_HZ = `RTC_OSC_HZ
) (
   input wire logic clk,        // System clock
   input wire logic rst,        // Async reset, high
   input wire logic run,        // Oscillator running
   input wire logic adj,        // This second is corrected
   input wire logic adj_pos,    // Correction direction
   output logic sec_tick,       // One-cycle second pulse
   output logic test_wave       // 512 Hz square wave
);
   logic [31:0] acc_r;
   logic [15:0] div_r;
   logic [5:0] tw_r;
   logic [31:0] sum;
   logic osc_tick;
   logic [15:0] period;
   logic div_end;
   // Phase accumulator turns the system clock into oscillator ticks
   assign sum = acc_r + 32'(OSC_HZ);
   assign osc_tick = run && (sum >= 32'(CLK_HZ));
   // Divide-by-256 stage drops 128 ticks or splits in 256 extra
   assign period = !adj ? `RTC_SEC_NOM :
                   (adj_pos ? `RTC_SEC_SHORT : `RTC_SEC_LONG);
   // Compare with >= so a period shortened mid-second still ends it
   assign div_end = osc_tick && (div_r >= period - 16'h0001);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_r <= 32'h0;
         div_r <= 16'h0;
         tw_r <= 6'h0;
         sec_tick <= 1'b0;
         test_wave <= 1'b0;
      end else begin
         if (run) acc_r <= osc_tick ? sum - 32'(CLK_HZ) : sum;
         if (osc_tick) div_r <= div_end ? 16'h0 : div_r + 16'h0001;
         // Own counter so calibration never shifts the test rate
         if (osc_tick) tw_r <= tw_r + 6'h01;
         sec_tick <= div_end;
         test_wave <= tw_r[`RTC_TEST_BIT];
      end
   end
endmodule // rtc_tbase
`default_nettype wire
